/* dskip_regs.svh */
/*
 * Register map, opcode patterns, field positions and timing figures of the
 * decrement-and-skip execution block. Assumes 32-bit AHB-Lite word access.
 */
//
// Behaviour
// - opcode 0100 11da ffff ffff decrements register
// - d=0 to accumulator, d=1 back
// - non-zero result discards fetched next instruction
// - a=0 access bank, a=1 bank pointer
// - a=0, extended set, f<=5Fh: indexed
// - skip over two-word instruction: three cycles
// - skip cycles idle in all four quarters
// - one word; one cycle, two when skipping
// - companion variant skips only on zero
`ifndef DSKIP_REGS_SVH
`define DSKIP_REGS_SVH

`define REG_CTRL         8'h00
`define REG_INSTR        8'h04
`define REG_STATUS       8'h08
`define REG_ACCUM        8'h0C
`define REG_INDEX        8'h10
`define REG_DATA_ADDR    8'h14
`define REG_DATA         8'h18
`define REG_ARITH        8'h1C

`define CTRL_EXT_BIT     0
`define CTRL_BANK_LSB    8
`define CTRL_BANK_MSB    11
`define INSTR_TWO_BIT    16
`define STAT_BUSY_BIT    0
`define STAT_SKIP_BIT    1
`define STAT_ILL_BIT     2
`define STAT_CYC_LSB     8
`define STAT_CYC_MSB     9
`define STAT_RES_LSB     16
`define STAT_RES_MSB     23

`define OPC_SKIP_NZ      6'h13
`define OPC_SKIP_Z       6'h0B
`define ACCESS_LIMIT     8'h5F
`define ACCESS_HI_BANK   4'hF
`define ACCESS_LO_BANK   4'h0
`define DATA_ADDR_W      12
`define DEC_STEP         8'h01
`define RESULT_ZERO      8'h00
`define CYC_ONE          2'h1

`define AHB_OKAY         1'b0
`define AHB_TRANS_BIT    1
`define ADDR_LSB         0
`define ADDR_MSB         7

`endif

/* dskip_pkg.sv */
/*
 * Types shared by the decrement-and-skip block: instruction fields,
 * captured bus address phase, execution and quarter-phase states.
 * Assumes nothing beyond the constants header.
 */
`default_nettype none
package dskip_pkg;

    typedef struct packed {
        logic [5:0] opcode;
        logic       dest;
        logic       access;
        logic [7:0] file;
    } instr_s;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_cap_s;

    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_e;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SKIP1, ST_SKIP2} exec_e;

endpackage
`default_nettype wire

/* quarter_phase.sv */
/*
 * Quarter-phase sequencer: a clock divider gives a one-cycle tick per
 * quarter, and a phase counter steps Q1..Q4 while run is high.
 * Assumes run is synchronous to clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module quarter_phase #(
    parameter int unsigned DIV = 1
) (
    input  wire logic              clk_i,   // system clock
    input  wire logic              rst_n_i, // async reset, active low
    input  wire logic              run_i,   // sequence running
    output logic                   tick_o,  // quarter end pulse
    output dskip_pkg::quarter_e    phase_o  // current quarter
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] div_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            div_reg <= '0;
        else if (!run_i || tick_o)
            div_reg <= '0;
        else
            div_reg <= div_reg + CW'(1);
    end

    assign tick_o = run_i && (div_reg == CW'(DIV - 1));

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_o <= dskip_pkg::Q1;
        else if (!run_i)
            phase_o <= dskip_pkg::Q1;
        else if (tick_o)
            phase_o <= dskip_pkg::quarter_e'(phase_o + 2'h1);
    end
endmodule
`default_nettype wire

/* dskip_core.sv */
/*
 * Execution unit for the decrement-and-skip pair, with its own data
 * memory, accumulator and bank pointer, reached over AHB-Lite.
 * Assumes single word transfers from one master; answers with no wait.
 */
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dskip_regs.svh"
module dskip_core #(
    parameter int unsigned Q_DIV = 1
) (
    input  wire logic        CLOCK_I,     // 10 MHz clock
    input  wire logic        RESETN_I,    // async reset, active low
    input  wire logic        HSEL_I,      // slave select
    input  wire logic [31:0] HADDR_I,     // byte address
    input  wire logic [1:0]  HTRANS_I,    // transfer type
    input  wire logic        HWRITE_I,    // write when high
    input  wire logic [2:0]  HSIZE_I,     // transfer size
    input  wire logic [31:0] HWDATA_I,    // write data
    input  wire logic        HREADY_I,    // bus ready
    output logic      [31:0] HRDATA_O,    // read data
    output logic             HREADYOUT_O, // slave ready
    output logic             HRESP_O,     // response, always okay
    output logic             BUSY_O,      // instruction executing
    output logic      [1:0]  QPHASE_O     // current quarter
);
    localparam int AW = `DATA_ADDR_W;

    logic [7:0]            mem [0:(1 << AW) - 1];
    dskip_pkg::instr_s     instr_reg;
    dskip_pkg::ahb_cap_s   cap_reg;
    dskip_pkg::exec_e      state_reg;
    dskip_pkg::quarter_e   phase;
    logic                  tick;
    logic                  ext_reg;
    logic [3:0]            bank_reg;
    logic [AW-1:0]         index_reg;
    logic [AW-1:0]         daddr_reg;
    logic [AW-1:0]         eaddr_reg;
    logic [7:0]            accum_reg;
    logic [7:0]            operand_reg;
    logic [7:0]            result_reg;
    logic [4:0]            arith_reg;
    logic [1:0]            cycles_reg;
    logic                  two_word_reg;
    logic                  skip_reg;
    logic                  illegal_reg;
    logic                  start;
    logic                  bus_wr;
    logic                  addr_ok;
    logic                  is_nz;
    logic                  is_z;
    logic                  exec_end;

    function automatic logic [AW-1:0] eff_addr(
        input dskip_pkg::instr_s i,
        input logic              ext,
        input logic [3:0]        bank,
        input logic [AW-1:0]     idx
    );
        logic low;
        low = (i.file <= `ACCESS_LIMIT);
        if (i.access)
            eff_addr = {bank, i.file};
        else if (ext && low)
            eff_addr = idx + {`ACCESS_LO_BANK, i.file};
        else if (low)
            eff_addr = {`ACCESS_LO_BANK, i.file};
        else
            eff_addr = {`ACCESS_HI_BANK, i.file};
    endfunction

    function automatic logic is_opc(
        input logic [15:0] w,
        input logic [5:0]  opc
    );
        is_opc = (w[15:10] == opc);
    endfunction

    quarter_phase #(
        .DIV (Q_DIV)
    ) u_quarter (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESETN_I),
        .run_i   (state_reg != dskip_pkg::ST_IDLE),
        .tick_o  (tick),
        .phase_o (phase)
    );

    // bus address phase capture and data phase write strobe
    assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[`AHB_TRANS_BIT];
    assign bus_wr  = cap_reg.valid && cap_reg.write;
    assign is_nz   = is_opc(HWDATA_I[15:0], `OPC_SKIP_NZ);
    assign is_z    = is_opc(HWDATA_I[15:0], `OPC_SKIP_Z);
    assign start   = bus_wr && (cap_reg.addr == `REG_INSTR)
                     && (state_reg == dskip_pkg::ST_IDLE) && (is_nz || is_z);
    assign exec_end = tick && (phase == dskip_pkg::Q4);

    always_ff @(posedge CLOCK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            cap_reg <= '0;
        else if (HREADY_I)
        begin
            cap_reg.valid <= addr_ok;
            cap_reg.write <= HWRITE_I;
            cap_reg.addr  <= HADDR_I[`ADDR_MSB:`ADDR_LSB];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            HREADYOUT_O <= 1'b0;
            HRESP_O     <= `AHB_OKAY;
            HRDATA_O    <= '0;
        end
        else
        begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= `AHB_OKAY;
            if (addr_ok && !HWRITE_I)
            begin
                HRDATA_O <= '0;
                unique case (HADDR_I[`ADDR_MSB:`ADDR_LSB])
                    `REG_CTRL:
                    begin
                        HRDATA_O[`CTRL_EXT_BIT] <= ext_reg;
                        HRDATA_O[`CTRL_BANK_MSB:`CTRL_BANK_LSB] <= bank_reg;
                    end
                    `REG_INSTR:
                    begin
                        HRDATA_O[15:0] <= instr_reg;
                        HRDATA_O[`INSTR_TWO_BIT] <= two_word_reg;
                    end
                    `REG_STATUS:
                    begin
                        HRDATA_O[`STAT_BUSY_BIT] <=
                            (state_reg != dskip_pkg::ST_IDLE);
                        HRDATA_O[`STAT_SKIP_BIT] <= skip_reg;
                        HRDATA_O[`STAT_ILL_BIT]  <= illegal_reg;
                        HRDATA_O[`STAT_CYC_MSB:`STAT_CYC_LSB] <= cycles_reg;
                        HRDATA_O[`STAT_RES_MSB:`STAT_RES_LSB] <= result_reg;
                    end
                    `REG_ACCUM:     HRDATA_O[7:0]    <= accum_reg;
                    `REG_INDEX:     HRDATA_O[AW-1:0] <= index_reg;
                    `REG_DATA_ADDR: HRDATA_O[AW-1:0] <= daddr_reg;
                    `REG_DATA:      HRDATA_O[7:0]    <= mem[daddr_reg];
                    `REG_ARITH:     HRDATA_O[4:0]    <= arith_reg;
                    default:        HRDATA_O         <= '0;
                endcase
            end
        end
    end

    // configuration written by software; refused while executing
    always_ff @(posedge CLOCK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            ext_reg   <= 1'b0;
            bank_reg  <= '0;
            index_reg <= '0;
            daddr_reg <= '0;
            arith_reg <= '0;
        end
        else if (bus_wr && state_reg == dskip_pkg::ST_IDLE)
        begin
            unique case (cap_reg.addr)
                `REG_CTRL:
                begin
                    ext_reg  <= HWDATA_I[`CTRL_EXT_BIT];
                    bank_reg <= HWDATA_I[`CTRL_BANK_MSB:`CTRL_BANK_LSB];
                end
                `REG_INDEX:     index_reg <= HWDATA_I[AW-1:0];
                `REG_DATA_ADDR: daddr_reg <= HWDATA_I[AW-1:0];
                `REG_ARITH:     arith_reg <= HWDATA_I[4:0];
                default:        ;
            endcase
        end
    end

    // instruction word, kind check and the execution sequence
    always_ff @(posedge CLOCK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            state_reg    <= dskip_pkg::ST_IDLE;
            instr_reg    <= '0;
            two_word_reg <= 1'b0;
            illegal_reg  <= 1'b0;
            cycles_reg   <= '0;
        end
        else
        begin
            if (bus_wr && cap_reg.addr == `REG_INSTR
                && state_reg == dskip_pkg::ST_IDLE)
            begin
                instr_reg    <= HWDATA_I[15:0];
                two_word_reg <= HWDATA_I[`INSTR_TWO_BIT];
                illegal_reg  <= !(is_nz || is_z);
            end
            unique case (state_reg)
                dskip_pkg::ST_IDLE:
                    if (start)
                    begin
                        state_reg  <= dskip_pkg::ST_EXEC;
                        cycles_reg <= '0;
                    end
                dskip_pkg::ST_EXEC:
                    if (exec_end)
                    begin
                        cycles_reg <= `CYC_ONE;
                        state_reg  <= skip_reg ? dskip_pkg::ST_SKIP1
                                               : dskip_pkg::ST_IDLE;
                    end
                dskip_pkg::ST_SKIP1:
                    if (exec_end)
                    begin
                        cycles_reg <= cycles_reg + 2'h1;
                        state_reg  <= two_word_reg ? dskip_pkg::ST_SKIP2
                                                   : dskip_pkg::ST_IDLE;
                    end
                dskip_pkg::ST_SKIP2:
                    if (exec_end)
                    begin
                        cycles_reg <= cycles_reg + 2'h1;
                        state_reg  <= dskip_pkg::ST_IDLE;
                    end
            endcase
        end
    end

    // per-quarter datapath of the executing cycle; skip cycles do nothing
    always_ff @(posedge CLOCK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            eaddr_reg   <= '0;
            operand_reg <= '0;
            result_reg  <= '0;
            skip_reg    <= 1'b0;
        end
        else if (start)
            skip_reg <= 1'b0;
        else if (tick && state_reg == dskip_pkg::ST_EXEC)
        begin
            unique case (phase)
                dskip_pkg::Q1:
                    eaddr_reg <= eff_addr(instr_reg, ext_reg, bank_reg,
                                          index_reg);
                dskip_pkg::Q2: operand_reg <= mem[eaddr_reg];
                dskip_pkg::Q3:
                begin
                    result_reg <= operand_reg - `DEC_STEP;
                    if (is_opc(instr_reg, `OPC_SKIP_NZ))
                        skip_reg <= (operand_reg - `DEC_STEP)
                                    != `RESULT_ZERO;
                    else
                        skip_reg <= (operand_reg - `DEC_STEP)
                                    == `RESULT_ZERO;
                end
                dskip_pkg::Q4: ;
            endcase
        end
    end

    // destination write in Q4, software write to data memory when idle
    always_ff @(posedge CLOCK_I)
    begin
        if (exec_end && state_reg == dskip_pkg::ST_EXEC
            && instr_reg.dest)
            mem[eaddr_reg] <= result_reg;
        else if (bus_wr && cap_reg.addr == `REG_DATA
                 && state_reg == dskip_pkg::ST_IDLE)
            mem[daddr_reg] <= HWDATA_I[7:0];
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            accum_reg <= '0;
        else if (exec_end && state_reg == dskip_pkg::ST_EXEC
                 && !instr_reg.dest)
            accum_reg <= result_reg;
        else if (bus_wr && cap_reg.addr == `REG_ACCUM
                 && state_reg == dskip_pkg::ST_IDLE)
            accum_reg <= HWDATA_I[7:0];
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            BUSY_O   <= 1'b0;
            QPHASE_O <= '0;
        end
        else
        begin
            BUSY_O   <= (state_reg != dskip_pkg::ST_IDLE);
            QPHASE_O <= phase;
        end
    end
endmodule
`default_nettype wire

/* dskip_sva.sv */
/*
 * Checker for the decrement-and-skip block: bus answer and execution timing.
 * Assumes binding to dskip_core with one clock per quarter.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dskip_regs.svh"
module dskip_sva #(
    parameter int unsigned Q_DIV = 1
) (
    input wire logic        CLOCK_I,     // clock
    input wire logic        RESETN_I,    // reset, low
    input wire logic        HSEL_I,      // select
    input wire logic [31:0] HADDR_I,     // address
    input wire logic [1:0]  HTRANS_I,    // transfer
    input wire logic        HWRITE_I,    // write
    input wire logic        HREADY_I,    // ready in
    input wire logic [31:0] HRDATA_O,    // read data
    input wire logic        HREADYOUT_O, // ready out
    input wire logic        HRESP_O,     // response
    input wire logic        BUSY_O,      // busy
    input wire logic [1:0]  QPHASE_O     // quarter
);
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RESETN_I);
    logic [4:0] bcnt;
    wire logic  take;
    wire logic  instr_wr;
    assign take = HSEL_I && HREADY_I && HTRANS_I[1];
    assign instr_wr = take && HWRITE_I && (HADDR_I[7:0] == `REG_INSTR);
    // length of the current busy stretch
    always_ff @(posedge CLOCK_I or negedge RESETN_I)
        if (!RESETN_I)
            bcnt <= 5'h00;
        else if (BUSY_O)
            bcnt <= bcnt + 5'h01;
        else
            bcnt <= 5'h00;
    chk_resp_okay: assert property (HRESP_O == 1'b0)
        else $error("response not okay");
    chk_ready_high: assert property ($past(RESETN_I) |-> HREADYOUT_O)
        else $error("wait state inserted");
    chk_rdata_hold: assert property (!(take && !HWRITE_I)
        |=> $stable(HRDATA_O))
        else $error("read data changed without a read");
    chk_busy_cause: assert property ($rose(BUSY_O) |->
        $past(instr_wr, 2) || $past(instr_wr, 3) || $past(instr_wr, 4))
        else $error("busy without instruction write");
    chk_busy_min: assert property ($rose(BUSY_O) |-> BUSY_O[*4])
        else $error("execution shorter than one cycle");
    chk_busy_max: assert property ($rose(BUSY_O) |-> ##[1:12] !BUSY_O)
        else $error("execution longer than three cycles");
    chk_busy_whole: assert property ($fell(BUSY_O) |->
        (bcnt == 5'h04) || (bcnt == 5'h08) || (bcnt == 5'h0C))
        else $error("execution not whole cycles");
    chk_phase_step: assert property (BUSY_O && $past(BUSY_O) &&
        $past(BUSY_O, 2) |-> QPHASE_O == $past(QPHASE_O) + 2'h1)
        else $error("quarter did not advance");
endmodule
`default_nettype wire

/* decrement_skip_execute_tb.sv */
/*
 * Testbench for the decrement-and-skip block over AHB-Lite.
 * Assumes zero-wait slave and data memory written before use.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dskip_regs.svh"
module decrement_skip_execute_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        busy;
    logic [31:0] rv;
    int          err_count = 0;
    int          n_compared = 0;
    always #50 clk = ~clk;
    dskip_core #(.Q_DIV(1)) uut (.CLOCK_I(clk), .RESETN_I(rst_n),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(), .BUSY_O(busy), .QPHASE_O());
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk);
        while (!hready) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hready) @(posedge clk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rv);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask
    task automatic run_case(input logic [5:0] opc, input logic d, a, ext,
        input logic [7:0] f, input logic [3:0] bank, input logic [11:0] idx,
        eff, input logic [7:0] val, input logic two);
        logic [7:0] res;
        logic       skip;
        logic [1:0] cyc;
        int         n;
        res = val - 8'h01;
        skip = (opc == `OPC_SKIP_NZ) ? (res != 8'h00) : (res == 8'h00);
        cyc = skip ? (two ? 2'h3 : 2'h2) : 2'h1;
        wr(`REG_CTRL, {20'h0, bank, 7'h0, ext});
        wr(`REG_INDEX, {20'h0, idx});
        wr(`REG_ACCUM, 32'h0000005A);
        wr(`REG_DATA_ADDR, {20'h0, eff});
        wr(`REG_DATA, {24'h0, val});
        wr(`REG_INSTR, {15'h0, two, opc, d, a, f});
        n = 0;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk);
            if (busy === 1'b1)
                n++;
        end
        @(posedge clk);
        chk(n, 4 * cyc);
        rd(`REG_STATUS, rv);
        chk(rv, {8'h0, res, 6'h0, cyc,
                 6'h0, skip, 1'b0});
        rd(`REG_ACCUM, rv);
        chk(rv, {24'h0, d ? 8'h5A : res});
        wr(`REG_DATA_ADDR, {20'h0, eff});
        rd(`REG_DATA, rv);
        chk(rv, {24'h0, d ? res : val});
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_of_test();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`REG_STATUS, rv);
        chk(rv, 32'h0);
        wr(`REG_ARITH, 32'h0000001F);
        run_case(`OPC_SKIP_NZ, 1'b1, 1'b1, 1'b0, 8'h20, 4'h3, 12'h0,
                 12'h320, 8'h05, 1'b0);
        run_case(`OPC_SKIP_NZ, 1'b0, 1'b1, 1'b0, 8'h21, 4'h3, 12'h0,
                 12'h321, 8'h01, 1'b0);
        run_case(`OPC_SKIP_NZ, 1'b1, 1'b0, 1'b1, 8'h5F, 4'h0, 12'h200,
                 12'h25F, 8'h00, 1'b1);
        run_case(`OPC_SKIP_Z, 1'b1, 1'b0, 1'b1, 8'h60, 4'h3, 12'h200,
                 12'hF60, 8'h01, 1'b0);
        run_case(`OPC_SKIP_Z, 1'b0, 1'b0, 1'b0, 8'h05, 4'h3, 12'h200,
                 12'h005, 8'h03, 1'b1);
        // long skip over a two-word instruction; accumulator write refused
        wr(`REG_INSTR, 32'h00014F20);
        rd(`REG_STATUS, rv);
        chk(rv & 32'h00000001, 32'h00000001);
        wr(`REG_ACCUM, 32'h00000033);
        repeat (16) @(posedge clk);
        rd(`REG_ACCUM, rv);
        chk(rv, 32'h00000002);
        rd(`REG_STATUS, rv);
        chk(rv, 32'h00030302);
        rd(`REG_ARITH, rv);
        chk(rv, 32'h0000001F);
        wr(`REG_INSTR, 32'h00002800);
        rd(`REG_STATUS, rv);
        chk(rv & 32'h00000005, 32'h00000004);
        rd(`REG_INSTR, rv);
        chk(rv, 32'h00002800);
        rd(8'h40, rv);
        chk(rv, 32'h0);
        end_of_test();
    end
endmodule
bind dskip_core dskip_sva #(.Q_DIV(Q_DIV)) u_sva (.CLOCK_I(CLOCK_I),
    .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .BUSY_O(BUSY_O), .QPHASE_O(QPHASE_O));
`default_nettype wire
